// file: pkg/cgc_cfg.svh
`ifndef CGC_CFG_SVH
`define CGC_CFG_SVH

// Register byte offsets on the bus.
`define CGC_OFS_PWR_MODE   8'h00
`define CGC_OFS_GATES_A    8'h04
`define CGC_OFS_GATES_B    8'h08
`define CGC_OFS_GATES_C    8'h0C
`define CGC_OFS_SRC_SEL    8'h10
`define CGC_OFS_DIV_SEL    8'h14
`define CGC_OFS_XTAL_EN    8'h18
`define CGC_OFS_PLL_CFG    8'h1C

// Reset values.
`define CGC_RST_PWR_MODE   8'h00
`define CGC_RST_GATES_A    8'h82
`define CGC_RST_GATES_B    8'h00
`define CGC_RST_GATES_C    8'h3E
`define CGC_RST_SRC_SEL    8'h00
`define CGC_RST_DIV_SEL    8'h00
`define CGC_RST_XTAL_EN    8'h00
`define CGC_RST_PLL_CFG    8'h00

// Power mode and memory gate fields.
`define CGC_B_SLEEP        0
`define CGC_B_HOLD         1
`define CGC_B_IDLE         2
`define CGC_F_MEM_HI       7
`define CGC_F_MEM_LO       4

// Gates C, source select and divider select fields.
`define CGC_B_SER_REF      7
`define CGC_B_OTP2RAM      6
`define CGC_B_BASS         5
`define CGC_B_AUDIO        4
`define CGC_B_RC_ON        1
`define CGC_B_ISP          0
`define CGC_B_OTP_HALF     7
`define CGC_B_WD_SEL       4
`define CGC_B_BCLK_SEL     5
`define CGC_B_DEC_HALF     4

// Crystal enables and PLL configuration fields.
`define CGC_B_XLOW_ON      7
`define CGC_B_XHIGH_ON     6
`define CGC_B_XDBL_ON      5
`define CGC_B_PLL_RC_IN    7
`define CGC_B_PLL_XTAL_IN  6
`define CGC_B_PLL_SSC      5
`define CGC_B_PLL_XDIV     4
`define CGC_B_PLL_DIG      1
`define CGC_B_PLL_ANA      0

`define CGC_CODE_RESERVED  2'h3
`define CGC_RESET_VECTOR   16'h8000

`endif

// file: pkg/cgc_pkg.sv
package cgc_pkg;

    typedef enum logic [1:0] {
        CGC_SYS_RC,
        CGC_SYS_XTAL,
        CGC_SYS_PLL
    } cgc_sys_src_t;

    typedef enum logic [1:0] {
        CGC_TK_XTAL,
        CGC_TK_RC,
        CGC_TK_DIV12
    } cgc_tk_src_t;

    typedef enum logic [1:0] {
        CGC_AU_XTAL_INV,
        CGC_AU_XTAL,
        CGC_AU_PLL_INV,
        CGC_AU_PLL
    } cgc_audio_src_t;

endpackage

// file: hw/cgc_clk_div.sv
`timescale 1ns/100ps

module cgc_clk_div
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] ratio,
    output logic            tick
);

    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;

    // A new ratio is loaded only when the count wraps, so a change never
    // shortens the running period.
    always_comb
    begin
        if (cnt_r == 3'h0)
            cnt_nxt = 3'(({2'h0, 1'b1} << ratio) - 3'h1);
        else
            cnt_nxt = cnt_r - 3'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cnt_r <= 3'h0;
        else
            cnt_r <= cnt_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tick <= 1'b0;
        else
            tick <= (cnt_r == 3'h0);
    end

endmodule

// file: hw/cgc_clock_ctrl.sv
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "cgc_cfg.svh"

// How it works
// - A seconds or alarm event resets the chip if timekeeper reset is on.
// - Watchdog overflow resets the chip whenever it occurs.
// - Port wakeup during sleep resets the chip instead of resuming.
// - Power mode bits 2,1,0 enter idle, hold and sleep when written 1.
// - Mode register bits 7..4 are active-low memory clock gates.
// - Gate register A holds eight active-low gates; DAC, decoder B start off.
// - Gate register B holds eight active-low gates, all on after reset.
// - Gate C bit 7 picks serial reference, bit 1 runs RC, bits 6,5,4,0 gates.
// - OTP clock runs at half the system rate when its bit is set.
// - Two-bit RC field picks 512K, 32K, 6M or 12M oscillator rate.
// - Watchdog clock comes from RC when 0, from a crystal when 1.
// - Timekeeper clock: crystal, RC, or 32K from 12M crystal; 11 reserved.
// - System source: 512K RC, crystal, or divided PLL; 11 reserved.
// - Audio clock: inverted or plain 12M crystal, inverted or plain PLL.
// - Bit clock source is the system clock or the 12M crystal.
// - Decoder clock runs at half the system rate when its bit is set.
// - System divide field divides the source by 1, 2, 4 or 8.
// - PLL divide field selects 48, 24, 16 or 12MHz output.
// - Crystal register bits 7,6,5 enable low, high crystal and doubler.
// - PLL bit 0 runs analog, bit 1 digital; divide change needs bit 1.
// - PLL reference field and input selects pick the PLL reference clock.
// - All reset sources are ORed; the CPU restarts at address 8000h.
// - Sleep stops every clock source; waking from sleep resets the chip.
// - Hold stops the system clock, idle only the CPU; interrupts end idle.
module cgc_clock_ctrl
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic                    timekeeperResetEnable,
    input  wire logic                    tkSecondEvt,
    input  wire logic                    tkAlarmEvt,
    input  wire logic                    wdOverflow,
    input  wire logic                    portWakeup,
    input  wire logic                    irqPending,
    input  wire logic                    holdWake,
    output logic                         sysRstReq,
    output logic      [15:0]             resetVector,
    output logic                         sysClkTick,
    output logic                         cpuClkTick,
    output logic                         decClkTick,
    output logic                         otpClkTick,
    output logic      [3:0]              memGateOn,
    output logic      [7:0]              periphGateOnA,
    output logic      [7:0]              periphGateOnB,
    output logic      [3:0]              periphGateOnC,
    output cgc_pkg::cgc_sys_src_t        sysSrcSel,
    output cgc_pkg::cgc_tk_src_t         tkSrcSel,
    output cgc_pkg::cgc_audio_src_t      audioSrcSel,
    output logic                         wdSrcSel,
    output logic                         bitClkSel,
    output logic                         serialRefSel,
    output logic      [1:0]              rcFreqSel,
    output logic                         rcOscOn,
    output logic                         crystalLowOn,
    output logic                         crystalHighOn,
    output logic                         crystalDoublerOn,
    output logic                         pllAnalogOn,
    output logic                         pllDigitalOn,
    output logic      [1:0]              pllOutDiv,
    output logic      [1:0]              pllRefSel,
    output logic                         pllCrystalInSel,
    output logic                         pllRcInSel,
    output logic                         crystalDividerOn,
    output logic                         pllSpreadOn,
    output logic                         idleMode,
    output logic                         holdMode,
    output logic                         sleepMode
);
    import cgc_pkg::*;

    localparam logic [7:0] RST_VAL [8] = '{
        `CGC_RST_PWR_MODE, `CGC_RST_GATES_A, `CGC_RST_GATES_B,
        `CGC_RST_GATES_C, `CGC_RST_SRC_SEL, `CGC_RST_DIV_SEL,
        `CGC_RST_XTAL_EN, `CGC_RST_PLL_CFG};

    logic [7:0] regs_r [8];
    logic       sysRst;
    logic       wrPend_r;
    logic       addrOk_r;
    logic [2:0] addrIdx_r;
    logic       wrEn;
    logic       rdTake;
    logic [3:0] evtMeta_r;
    logic [3:0] evtSync_r;
    logic [3:0] evtLast_r;
    logic [3:0] evtRise;
    logic       rstSrc;
    logic       divTick;
    logic       decPhase_r;
    logic       otpPhase_r;
    logic [1:0] sysDivCode;

    assign sysRst = !rst_n || sysRstReq;
    assign resetVector = `CGC_RESET_VECTOR;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Bus address phase. Zero wait states, so hready is always ours.
    assign rdTake = hsel && hready && htrans[1] && !hwrite;
    assign wrEn = wrPend_r && addrOk_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrPend_r <= 1'b0;
            addrOk_r <= 1'b0;
            addrIdx_r <= 3'h0;
        end
        else
        begin
            wrPend_r <= hsel && hready && htrans[1] && hwrite;
            addrOk_r <= (haddr[31:5] == 27'h0);
            addrIdx_r <= haddr[4:2];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            hrdata <= 32'h0;
        else if (rdTake && haddr[31:5] == 27'h0)
            hrdata <= {24'h0, regs_r[haddr[4:2]]};
        else if (rdTake)
            hrdata <= 32'h0;
    end

    // Register file. A software write comes last so that it beats a
    // hardware clear of a mode bit in the same cycle.
    always_ff @(posedge clk)
    begin
        if (sysRst)
        begin
            for (int i = 0; i < 8; i++)
                regs_r[i] <= RST_VAL[i];
        end
        else
        begin
            if (irqPending)
                regs_r[0][`CGC_B_IDLE] <= 1'b0;
            if (holdWake)
                regs_r[0][`CGC_B_HOLD] <= 1'b0;
            if (wrEn)
                regs_r[addrIdx_r] <= hwdata[7:0];
        end
    end

    assign idleMode = regs_r[0][`CGC_B_IDLE];
    assign holdMode = regs_r[0][`CGC_B_HOLD];
    assign sleepMode = regs_r[0][`CGC_B_SLEEP];

    // Event pins are asynchronous to clk and are caught on their rise.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    evtMeta_r[g] <= 1'b0;
                    evtSync_r[g] <= 1'b0;
                    evtLast_r[g] <= 1'b0;
                end
                else
                begin
                    evtMeta_r[g] <= g == 0 ? tkSecondEvt :
                                    g == 1 ? tkAlarmEvt :
                                    g == 2 ? wdOverflow : portWakeup;
                    evtSync_r[g] <= evtMeta_r[g];
                    evtLast_r[g] <= evtSync_r[g];
                end
            end
            assign evtRise[g] = evtSync_r[g] && !evtLast_r[g];
        end
    endgenerate

    // A port wakeup outside sleep is an ordinary interrupt, not a reset.
    assign rstSrc = (timekeeperResetEnable
                     && (evtRise[0] || evtRise[1]))
                 || evtRise[2]
                 || (sleepMode && evtRise[3]);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sysRstReq <= 1'b0;
        else
            sysRstReq <= rstSrc;
    end

    assign sysDivCode = regs_r[5][3:2];

    cgc_clk_div u_system_divide
    (
        .clk   (clk),
        .rst_n (rst_n),
        .ratio (sysDivCode),
        .tick  (divTick)
    );

    // Hold stops the system clock while sources keep running.
    assign sysClkTick = divTick && !holdMode && !sleepMode;
    assign cpuClkTick = sysClkTick && !idleMode;

    always_ff @(posedge clk)
    begin
        if (sysRst)
        begin
            decPhase_r <= 1'b0;
            otpPhase_r <= 1'b0;
        end
        else if (sysClkTick)
        begin
            decPhase_r <= !decPhase_r;
            otpPhase_r <= !otpPhase_r;
        end
    end

    assign decClkTick = sysClkTick &&
        (!regs_r[5][`CGC_B_DEC_HALF] || decPhase_r);
    assign otpClkTick = sysClkTick &&
        (!regs_r[4][`CGC_B_OTP_HALF] || otpPhase_r);

    // Gates and clock selects only move on a divided period boundary, so a
    // write never chops a pulse short. Reserved codes leave the old source.
    always_ff @(posedge clk)
    begin
        if (sysRst)
        begin
            memGateOn <= ~RST_VAL[0][`CGC_F_MEM_HI:`CGC_F_MEM_LO];
            periphGateOnA <= ~`CGC_RST_GATES_A;
            periphGateOnB <= ~`CGC_RST_GATES_B;
            periphGateOnC <= ~{RST_VAL[3][`CGC_B_OTP2RAM:`CGC_B_AUDIO],
                               RST_VAL[3][`CGC_B_ISP]};
            sysSrcSel <= CGC_SYS_RC;
            tkSrcSel <= CGC_TK_XTAL;
            audioSrcSel <= CGC_AU_XTAL_INV;
            wdSrcSel <= 1'b0;
            bitClkSel <= 1'b0;
            serialRefSel <= 1'b0;
        end
        else if (divTick)
        begin
            memGateOn <= ~regs_r[0][`CGC_F_MEM_HI:`CGC_F_MEM_LO];
            periphGateOnA <= ~regs_r[1];
            periphGateOnB <= ~regs_r[2];
            periphGateOnC <= ~{regs_r[3][`CGC_B_OTP2RAM],
                               regs_r[3][`CGC_B_BASS],
                               regs_r[3][`CGC_B_AUDIO],
                               regs_r[3][`CGC_B_ISP]};
            if (regs_r[4][1:0] != `CGC_CODE_RESERVED)
                sysSrcSel <= cgc_sys_src_t'(regs_r[4][1:0]);
            if (regs_r[4][3:2] != `CGC_CODE_RESERVED)
                tkSrcSel <= cgc_tk_src_t'(regs_r[4][3:2]);
            audioSrcSel <= cgc_audio_src_t'(regs_r[5][7:6]);
            wdSrcSel <= regs_r[4][`CGC_B_WD_SEL];
            bitClkSel <= regs_r[5][`CGC_B_BCLK_SEL];
            serialRefSel <= regs_r[3][`CGC_B_SER_REF];
        end
    end

    // Oscillator and PLL controls. Sleep forces every source off.
    always_ff @(posedge clk)
    begin
        if (sysRst)
        begin
            rcOscOn <= RST_VAL[3][`CGC_B_RC_ON];
            crystalLowOn <= 1'b0;
            crystalHighOn <= 1'b0;
            crystalDoublerOn <= 1'b0;
            pllAnalogOn <= 1'b0;
            pllDigitalOn <= 1'b0;
            rcFreqSel <= 2'h0;
            pllRefSel <= 2'h0;
            pllCrystalInSel <= 1'b0;
            pllRcInSel <= 1'b0;
            crystalDividerOn <= 1'b0;
            pllSpreadOn <= 1'b0;
        end
        else
        begin
            rcOscOn <= regs_r[3][`CGC_B_RC_ON] && !sleepMode;
            crystalLowOn <= regs_r[6][`CGC_B_XLOW_ON]
                && !sleepMode;
            crystalHighOn <= regs_r[6][`CGC_B_XHIGH_ON]
                && !sleepMode;
            crystalDoublerOn <= regs_r[6][`CGC_B_XDBL_ON]
                && !sleepMode;
            pllAnalogOn <= regs_r[7][`CGC_B_PLL_ANA]
                && !sleepMode;
            pllDigitalOn <= regs_r[7][`CGC_B_PLL_DIG]
                && !sleepMode;
            rcFreqSel <= regs_r[4][6:5];
            pllRefSel <= regs_r[7][3:2];
            pllCrystalInSel <= regs_r[7][`CGC_B_PLL_XTAL_IN];
            pllRcInSel <= regs_r[7][`CGC_B_PLL_RC_IN];
            crystalDividerOn <= regs_r[7][`CGC_B_PLL_XDIV];
            pllSpreadOn <= regs_r[7][`CGC_B_PLL_SSC];
        end
    end

    // The PLL divider only takes a new value when software writes the PLL
    // configuration with the digital enable set, as the PLL core needs.
    always_ff @(posedge clk)
    begin
        if (sysRst)
            pllOutDiv <= RST_VAL[5][1:0];
        else if (wrEn && addrIdx_r == 3'h7 && hwdata[`CGC_B_PLL_DIG])
            pllOutDiv <= regs_r[5][1:0];
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence tkEvt_s;
        timekeeperResetEnable && (evtRise[0] || evtRise[1]);
    endsequence

    sequence wakeInSleep_s;
        sleepMode && evtRise[3];
    endsequence

    sequence divBy2Tick_s;
        divTick ##1 !divTick ##1 divTick;
    endsequence

    tk_reset_a: assert property (tkEvt_s |=> sysRstReq)
        else $error("Timekeeper event did not reset.");
    wd_reset_a: assert property (evtRise[2] |=> sysRstReq)
        else $error("Watchdog overflow did not reset.");
    sleep_wake_a: assert property (wakeInSleep_s |=> sysRstReq)
        else $error("Sleep wakeup did not reset.");
    reset_defaults_a: assert property (sysRstReq |=>
        regs_r[1] == `CGC_RST_GATES_A && regs_r[3] == `CGC_RST_GATES_C
        && !sleepMode)
        else $error("Registers not restored by reset.");
    mode_write_a: assert property (wrEn && addrIdx_r == 3'h0
        && !sysRst |=> {idleMode, holdMode, sleepMode} == $past(hwdata[2:0]))
        else $error("Mode write lost.");
    sleep_osc_a: assert property (sleepMode && !sysRst ##1 sleepMode
        |-> !rcOscOn && !pllAnalogOn && !crystalHighOn)
        else $error("Source running in sleep.");
    idle_cpu_a: assert property (idleMode || holdMode |-> !cpuClkTick)
        else $error("CPU clocked in idle or hold.");
    sys_div_a: assert property (divTick && sysDivCode == 2'h1
        && $past(sysDivCode) == 2'h1 |-> divBy2Tick_s)
        else $error("Divide by two period wrong.");
    reserved_hold_a: assert property (regs_r[4][1:0] == 2'h3
        && !sysRst |=> $stable(sysSrcSel))
        else $error("Reserved code changed system source.");

endmodule

// file: bench/cgc_clk_sink.sv
`timescale 1ns/100ps

// Stands in for the CPU and the peripherals that take the clock enables.
// It only counts the enables, so the rate and the gating can be judged
// over a window without caring where the divider phase happens to be.
module cgc_clk_sink
(
    input  wire logic clk,
    input  wire logic clr,
    input  wire logic sysTick,
    input  wire logic cpuTick,
    input  wire logic decTick,
    input  wire logic otpTick,
    output int        sysCnt,
    output int        cpuCnt,
    output int        decCnt,
    output int        otpCnt
);
    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            sysCnt <= 0;
            cpuCnt <= 0;
            decCnt <= 0;
            otpCnt <= 0;
        end
        else
        begin
            sysCnt <= sysCnt + int'(sysTick === 1'b1);
            cpuCnt <= cpuCnt + int'(cpuTick === 1'b1);
            decCnt <= decCnt + int'(decTick === 1'b1);
            otpCnt <= otpCnt + int'(otpTick === 1'b1);
        end
    end
endmodule

// file: bench/tb_cgc_clock_ctrl.sv
`timescale 1ns/100ps
`include "cgc_cfg.svh"

module tb_cgc_clock_ctrl;
    import cgc_pkg::*;

    logic           clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]    haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [1:0]     htrans = 2'h0;
    logic           hreadyout, hresp, sysRstReq, clr = 1'b1;
    logic           timekeeperResetEnable = 1'b0, irqPending = 1'b0;
    logic           holdWake = 1'b0;
    logic [3:0]     evt = 4'h0;
    logic [15:0]    resetVector;
    logic           sysClkTick, cpuClkTick, decClkTick, otpClkTick;
    logic [3:0]     memGateOn, periphGateOnC;
    logic [7:0]     periphGateOnA, periphGateOnB;
    cgc_sys_src_t   sysSrcSel;
    cgc_tk_src_t    tkSrcSel;
    cgc_audio_src_t audioSrcSel;
    logic           wdSrcSel, bitClkSel, serialRefSel, rcOscOn;
    logic [1:0]     rcFreqSel, pllOutDiv, pllRefSel;
    logic           crystalLowOn, crystalHighOn, crystalDoublerOn;
    logic           pllAnalogOn, pllDigitalOn, pllCrystalInSel, pllRcInSel;
    logic           crystalDividerOn, pllSpreadOn;
    logic           idleMode, holdMode, sleepMode;
    int             errors = 0, tests_run = 0, cycles = 0, pulses = 0;
    int             sysCnt, cpuCnt, decCnt, otpCnt;
    logic [7:0]     rstv [8] = '{8'h00, 8'h82, 8'h00, 8'h3E,
                                 8'h00, 8'h00, 8'h00, 8'h00};

    cgc_clock_ctrl u_dut
    (
        .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .timekeeperResetEnable, .tkSecondEvt(evt[0]), .tkAlarmEvt(evt[1]),
        .wdOverflow(evt[2]), .portWakeup(evt[3]), .irqPending, .holdWake,
        .sysRstReq, .resetVector, .sysClkTick, .cpuClkTick, .decClkTick,
        .otpClkTick, .memGateOn, .periphGateOnA, .periphGateOnB,
        .periphGateOnC, .sysSrcSel, .tkSrcSel, .audioSrcSel, .wdSrcSel,
        .bitClkSel, .serialRefSel, .rcFreqSel, .rcOscOn, .crystalLowOn,
        .crystalHighOn, .crystalDoublerOn, .pllAnalogOn, .pllDigitalOn,
        .pllOutDiv, .pllRefSel, .pllCrystalInSel, .pllRcInSel,
        .crystalDividerOn, .pllSpreadOn, .idleMode, .holdMode, .sleepMode
    );

    cgc_clk_sink u_sink
    (
        .clk, .clr, .sysTick(sysClkTick), .cpuTick(cpuClkTick),
        .decTick(decClkTick), .otpTick(otpClkTick), .sysCnt, .cpuCnt,
        .decCnt, .otpCnt
    );

    always #50 clk = ~clk;

    task close_out();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (sysRstReq === 1'b1)
            pulses = pulses + 1;
        if (cycles == 20000)
        begin
            errors++;
            close_out();
        end
    end

    task check(input string name, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // The address phase is held until hready is seen high; read data is
    // taken at the edge that ends the data phase.
    task xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    task rd_chk(input string name, input logic [31:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        check(name, rdv, {24'h0, e});
    endtask

    task count(input int n);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        // The extra edge lets the last count settle before it is read.
        repeat (n + 1) @(posedge clk);
    endtask

    task fire(input int idx, input logic en, input int e, input string name);
        pulses = 0;
        @(posedge clk);
        timekeeperResetEnable <= en;
        evt[idx] <= 1'b1;
        repeat (8) @(posedge clk);
        evt[idx] <= 1'b0;
        repeat (4) @(posedge clk);
        check(name, pulses, e);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd_chk("reset value", 4 * i, rstv[i]);
        check("gates A", periphGateOnA, 8'h7D);
        check("gates B", periphGateOnB, 8'hFF);
        check("gates C", periphGateOnC, 4'h9);
        check("mem gates", memGateOn, 4'hF);
        check("rc on", rcOscOn, 1'b1);
        check("vector", resetVector, 16'h8000);
        xfer(1'b1, 32'h40, 8'h5A);
        rd_chk("unmapped", 32'h40, 8'h00);
        rd_chk("gates A", `CGC_OFS_GATES_A, 8'h82);
        xfer(1'b1, `CGC_OFS_PWR_MODE, 8'hA0);
        xfer(1'b1, `CGC_OFS_GATES_A, 8'h5A);
        xfer(1'b1, `CGC_OFS_GATES_B, 8'hC3);
        xfer(1'b1, `CGC_OFS_GATES_C, 8'hC1);
        repeat (20) @(posedge clk);
        check("mem gates", memGateOn, 4'h5);
        check("gates A", periphGateOnA, 8'hA5);
        check("gates B", periphGateOnB, 8'h3C);
        check("gates C", periphGateOnC, 4'h6);
        check("serial ref", serialRefSel, 1'b1);
        check("rc on", rcOscOn, 1'b0);
        rd_chk("gates C", `CGC_OFS_GATES_C, 8'hC1);
        // Code 3 comes last so the reserved code must keep code 2.
        for (int i = 0; i < 4; i++)
        begin
            logic [1:0] held;
            held = (i == 3) ? 2'h2 : i[1:0];
            xfer(1'b1, `CGC_OFS_SRC_SEL, {1'b0, i[1:0], 1'b1, i[1:0], i[1:0]});
            xfer(1'b1, `CGC_OFS_DIV_SEL, {i[1:0], i[0], 5'h00});
            repeat (20) @(posedge clk);
            check("rc freq", rcFreqSel, i[1:0]);
            check("audio src", audioSrcSel, i[1:0]);
            check("sys src", sysSrcSel, held);
            check("tk src", tkSrcSel, held);
            check("bit clk", bitClkSel, i[0]);
        end
        check("wd src", wdSrcSel, 1'b1);
        xfer(1'b1, `CGC_OFS_SRC_SEL, 8'h80);
        for (int d = 0; d < 4; d++)
        begin
            xfer(1'b1, `CGC_OFS_DIV_SEL, {3'h0, 1'b1, d[1:0], 2'h0});
            repeat (20) @(posedge clk);
            count(64);
            check("sys ticks", sysCnt, 64 >> d);
            check("dec ticks", decCnt, 32 >> d);
            check("otp ticks", otpCnt, 32 >> d);
        end
        xfer(1'b1, `CGC_OFS_DIV_SEL, 8'h02);
        xfer(1'b1, `CGC_OFS_PWR_MODE, 8'h04);
        count(32);
        check("idle", idleMode, 1'b1);
        check("cpu ticks", cpuCnt, 0);
        check("sys ticks", sysCnt, 32);
        irqPending <= 1'b1;
        @(posedge clk);
        irqPending <= 1'b0;
        repeat (4) @(posedge clk);
        check("idle end", idleMode, 1'b0);
        xfer(1'b1, `CGC_OFS_PWR_MODE, 8'h02);
        count(32);
        check("hold", holdMode, 1'b1);
        check("sys ticks", sysCnt, 0);
        holdWake <= 1'b1;
        @(posedge clk);
        holdWake <= 1'b0;
        repeat (4) @(posedge clk);
        check("hold end", holdMode, 1'b0);
        xfer(1'b1, `CGC_OFS_PLL_CFG, 8'hFD);
        repeat (4) @(posedge clk);
        check("pll div held", pllOutDiv, 2'h0);
        check("pll cfg", {pllRcInSel, pllCrystalInSel,
            pllSpreadOn, crystalDividerOn, pllRefSel, pllDigitalOn,
            pllAnalogOn}, 8'hFD);
        xfer(1'b1, `CGC_OFS_PLL_CFG, 8'h02);
        xfer(1'b1, `CGC_OFS_XTAL_EN, 8'hE0);
        repeat (4) @(posedge clk);
        check("pll div", pllOutDiv, 2'h2);
        check("crystals", {crystalLowOn, crystalHighOn,
            crystalDoublerOn}, 3'h7);
        // USB setup: a 48MHz PLL output feeds an undivided system clock.
        xfer(1'b1, `CGC_OFS_DIV_SEL, 8'h00);
        xfer(1'b1, `CGC_OFS_PLL_CFG, 8'h03);
        xfer(1'b1, `CGC_OFS_SRC_SEL, 8'h02);
        xfer(1'b1, `CGC_OFS_GATES_B, 8'h00);
        repeat (20) @(posedge clk);
        check("usb pll div", pllOutDiv, 2'h0);
        check("usb sys src", sysSrcSel, CGC_SYS_PLL);
        check("usb gate", periphGateOnB, 8'hFF);
        fire(0, 1'b0, 0, "second off");
        fire(0, 1'b1, 1, "second");
        rd_chk("crystal reg", `CGC_OFS_XTAL_EN, 8'h00);
        check("crystals", {crystalLowOn, crystalHighOn,
            crystalDoublerOn}, 3'h0);
        fire(1, 1'b1, 1, "alarm");
        fire(2, 1'b0, 1, "watchdog");
        fire(3, 1'b0, 0, "wake awake");
        xfer(1'b1, `CGC_OFS_PWR_MODE, 8'h01);
        count(16);
        check("sleep", sleepMode, 1'b1);
        check("sys ticks", sysCnt, 0);
        fire(3, 1'b0, 1, "wake sleep");
        check("sleep end", sleepMode, 1'b0);
        check("response", hresp, 1'b0);
        close_out();
    end
endmodule
